// file: rtl/capture_front.sv
// capture trigger front end: synchroniser, optional noise filter, edge select
// assumes the pin is asynchronous; the comparator level is on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "timer0_params.svh"
module capture_front
  import timer0_pkg::*;
#(
  parameter int SAMPLES = `NOISE_SAMPLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  input wire logic acomp_in,
  input wire logic use_acomp_in,
  input wire logic noise_en_in,
  input wire logic rising_in,
  output logic event_out
);
  logic sync1_reg;
  logic sync2_reg;
  logic [SAMPLES-1:0] hist_reg;
  logic filt_reg;
  logic prev_reg;
  logic raw;
  logic level;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  assign raw = use_acomp_in ? acomp_in : sync2_reg;

  // the filter output only moves after all samples agree, costing SAMPLES+1 cycles of delay
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      hist_reg <= '0;
      filt_reg <= 1'b0;
    end else begin
      hist_reg <= {hist_reg[SAMPLES-2:0], raw};
      if (&hist_reg)
        filt_reg <= 1'b1;
      else if (~|hist_reg)
        filt_reg <= 1'b0;
    end
  end

  assign level = noise_en_in ? filt_reg : raw;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      prev_reg <= 1'b0;
    else
      prev_reg <= level;
  end

  assign event_out = rising_in ? (level & ~prev_reg) : (~level & prev_reg);
endmodule
`default_nettype wire

// file: rtl/irq_flag_unit.sv
// sticky interrupt flags with mask and global enable gating
// assumes set, clear and acknowledge pulses come from the same clock
`timescale 1ns/1ns
`default_nettype none
module irq_flag_unit
  import timer0_pkg::*;
#(
  parameter int N = 4
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [N-1:0] set_in,
  input wire logic [N-1:0] clr_in,
  input wire logic [N-1:0] enable_in,
  input wire logic global_en_in,
  output logic [N-1:0] flags_out,
  output logic [N-1:0] irq_out
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_flag
      logic flag_bit_reg;
      // set wins over a clear in the same cycle so no event is lost
      always_ff @(posedge clk_in) begin
        if (!rst_n_in)
          flag_bit_reg <= 1'b0;
        else if (set_in[g])
          flag_bit_reg <= 1'b1;
        else if (clr_in[g])
          flag_bit_reg <= 1'b0;
      end
      assign flags_out[g] = flag_bit_reg;
      assign irq_out[g] = flag_bit_reg & enable_in[g] & global_en_in;
    end
  endgenerate
endmodule
`default_nettype wire

// file: rtl/timer0_params.svh
// constants for the timer register interface: offsets, bit positions, resets, counts
// assumes an 8-bit cpu i/o bus with 6-bit register addresses
`ifndef TIMER0_PARAMS_SVH
`define TIMER0_PARAMS_SVH

`define ADDR_COUNTER_LOW 6'h12
`define ADDR_COMPARE_A 6'h13
`define ADDR_COUNTER_HIGH 6'h14
`define ADDR_TIMER_CTRL 6'h15
`define ADDR_COMPARE_B 6'h16
`define ADDR_IRQ_FLAGS 6'h38
`define ADDR_IRQ_MASK 6'h39

`define CTRL_WIDTH_BIT 7
`define CTRL_CAPT_EN_BIT 6
`define CTRL_NOISE_BIT 5
`define CTRL_EDGE_BIT 4
`define CTRL_ACOMP_BIT 3
`define CTRL_CTC_BIT 0
`define CTRL_WRITE_MASK 8'hF9
`define MASK_WRITE_MASK 8'h1B

`define IRQ_COMPARE_A_BIT 4
`define IRQ_COMPARE_B_BIT 3
`define IRQ_OVERFLOW_BIT 1
`define IRQ_CAPTURE_BIT 0

`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define NOISE_SAMPLES 4

`endif

// file: rtl/timer0_pkg.sv
// types shared by the timer register interface files
// assumes timer0_params.svh supplies every number
package timer0_pkg;

  typedef struct packed {
    logic [5:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } io_req_s;

  typedef struct packed {
    logic capture;
    logic overflow;
    logic compare_b;
    logic compare_a;
  } irq_vec_s;

endpackage

// file: rtl/timer0_regs.sv
// timer0 counter, compare, capture and the register file behind the cpu i/o bus
// assumes a single-cycle cpu strobe bus on clk_in; tick_in is a prescaler enable
`timescale 1ns/1ns
`default_nettype none
`include "timer0_params.svh"
module timer0_regs
  import timer0_pkg::*;
#(
  parameter int NOISE = `NOISE_SAMPLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire io_req_s io_req_in,
  output logic [7:0] rdata_out,
  input wire logic tick_in,
  input wire logic capture_pin_in,
  input wire logic acomp_in,
  input wire logic global_irq_en_in,
  input wire irq_vec_s vector_ack_in,
  output irq_vec_s irq_out,
  output logic [15:0] count_out
);
  logic [7:0] count_low_reg;
  logic [7:0] count_high_reg;
  logic [7:0] compare_a_reg;
  logic [7:0] compare_b_reg;
  logic [7:0] temp_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] mask_reg;
  logic block_reg;
  logic [7:0] rdata_reg;
  logic [15:0] count_out_reg;

  logic wide;
  logic capt_mode;
  logic ctc_mode;
  logic [15:0] count16;
  logic [15:0] compare16;
  logic wr_low;
  logic wr_high;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_mask;
  logic rd_low;
  logic rd_cmp_a;
  logic match_a_raw;
  logic match_b_raw;
  logic at_top;
  logic at_max;
  logic capt_event;
  logic capture_take;
  logic top_reached;
  logic [15:0] count_inc;
  logic [3:0] set_vec;
  logic [3:0] clr_vec;
  logic [3:0] en_vec;
  logic [3:0] flag_vec;
  logic [3:0] irq_vec;
  logic [7:0] flags_byte;
  logic [7:0] rd_mux;

  assign wide = ctrl_reg[`CTRL_WIDTH_BIT];
  assign capt_mode = ctrl_reg[`CTRL_CAPT_EN_BIT];
  assign ctc_mode = ctrl_reg[`CTRL_CTC_BIT];
  assign count16 = {count_high_reg, count_low_reg};
  assign compare16 = {compare_b_reg, compare_a_reg};

  // address decode; unmapped addresses are ignored on write and read as zero
  assign wr_low = io_req_in.wr && (io_req_in.addr == `ADDR_COUNTER_LOW);
  assign wr_high = io_req_in.wr && (io_req_in.addr == `ADDR_COUNTER_HIGH);
  assign wr_cmp_a = io_req_in.wr && (io_req_in.addr == `ADDR_COMPARE_A);
  assign wr_cmp_b = io_req_in.wr && (io_req_in.addr == `ADDR_COMPARE_B);
  assign wr_ctrl = io_req_in.wr && (io_req_in.addr == `ADDR_TIMER_CTRL);
  assign wr_flags = io_req_in.wr && (io_req_in.addr == `ADDR_IRQ_FLAGS);
  assign wr_mask = io_req_in.wr && (io_req_in.addr == `ADDR_IRQ_MASK);
  assign rd_low = io_req_in.rd && (io_req_in.addr == `ADDR_COUNTER_LOW);
  assign rd_cmp_a = io_req_in.rd && (io_req_in.addr == `ADDR_COMPARE_A);

  capture_front #(
    .SAMPLES(NOISE)
  ) u_capture_front (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(capture_pin_in),
    .acomp_in(acomp_in),
    .use_acomp_in(ctrl_reg[`CTRL_ACOMP_BIT]),
    .noise_en_in(ctrl_reg[`CTRL_NOISE_BIT]),
    .rising_in(ctrl_reg[`CTRL_EDGE_BIT]),
    .event_out(capt_event)
  );

  // compare values; in wide mode both halves form one 16-bit value
  assign match_a_raw = wide ? (count16 == compare16) : (count_low_reg == compare_a_reg);
  // in wide mode this match only feeds nothing, since the flag is held off there
  assign match_b_raw = wide ? (count_high_reg == compare_b_reg) :
                       (count_low_reg == compare_b_reg);
  // in ctc mode the top value is compare_a (or the merged pair); capture into it is
  // then held off, and reaching top sets the capture flag when capture mode is on
  assign at_top = ctc_mode && match_a_raw;
  assign at_max = wide ? (count16 == 16'hFFFF) : (count_low_reg == 8'hFF);
  assign top_reached = tick_in && at_top && !block_reg;
  assign capture_take = capt_mode && capt_event && !ctc_mode;
  assign count_inc = count16 + 16'h0001;

  // a low write suppresses matching on the following timer tick
  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      block_reg <= 1'b0;
    else if (wr_low)
      block_reg <= 1'b1;
    else if (tick_in)
      block_reg <= 1'b0;
  end

  // flag set events; compare, overflow and top are evaluated on the tick that sees the current count, a capture edge sets its flag without a tick
  always_comb begin
    set_vec = 4'h0;
    if (tick_in && !block_reg) begin
      set_vec[3] = match_a_raw && !capt_mode;
      set_vec[2] = match_b_raw && !wide;
    end
    set_vec[1] = tick_in && at_max && !ctc_mode;
    set_vec[0] = capture_take || (capt_mode && top_reached);
  end

  // hardware acknowledge or a written one clears a flag
  always_comb begin
    clr_vec[3] = vector_ack_in.compare_a || (wr_flags && io_req_in.wdata[`IRQ_COMPARE_A_BIT]);
    clr_vec[2] = vector_ack_in.compare_b || (wr_flags && io_req_in.wdata[`IRQ_COMPARE_B_BIT]);
    clr_vec[1] = vector_ack_in.overflow || (wr_flags && io_req_in.wdata[`IRQ_OVERFLOW_BIT]);
    clr_vec[0] = vector_ack_in.capture || (wr_flags && io_req_in.wdata[`IRQ_CAPTURE_BIT]);
  end

  assign en_vec = {mask_reg[`IRQ_COMPARE_A_BIT], mask_reg[`IRQ_COMPARE_B_BIT],
                   mask_reg[`IRQ_OVERFLOW_BIT], mask_reg[`IRQ_CAPTURE_BIT]};

  irq_flag_unit #(
    .N(4)
  ) u_irq_flag_unit (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .set_in(set_vec),
    .clr_in(clr_vec),
    .enable_in(en_vec),
    .global_en_in(global_irq_en_in),
    .flags_out(flag_vec),
    .irq_out(irq_vec)
  );

  assign irq_out.compare_a = irq_vec[3];
  assign irq_out.compare_b = irq_vec[2];
  assign irq_out.overflow = irq_vec[1];
  assign irq_out.capture = irq_vec[0];

  always_comb begin
    flags_byte = `RESET_BYTE;
    flags_byte[`IRQ_COMPARE_A_BIT] = flag_vec[3];
    flags_byte[`IRQ_COMPARE_B_BIT] = flag_vec[2];
    flags_byte[`IRQ_OVERFLOW_BIT] = flag_vec[1];
    flags_byte[`IRQ_CAPTURE_BIT] = flag_vec[0];
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      ctrl_reg <= `RESET_BYTE;
    else if (wr_ctrl)
      ctrl_reg <= io_req_in.wdata & `CTRL_WRITE_MASK;
  end

  // only the four bits this timer owns are kept; the rest read as zero
  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      mask_reg <= `RESET_BYTE;
    else if (wr_mask)
      mask_reg <= io_req_in.wdata & `MASK_WRITE_MASK;
  end

  // shared high-byte latch: every 16-bit access passes through here, so an
  // interrupt handler touching another 16-bit register corrupts a half-done access
  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      temp_reg <= `RESET_BYTE;
    else if (wr_high || (wide && wr_cmp_b))
      temp_reg <= io_req_in.wdata;
    else if (wide && rd_low)
      temp_reg <= count_high_reg;
    else if (wide && rd_cmp_a)
      temp_reg <= compare_b_reg;
  end

  // counter low byte: bus writes win over counting, ctc clears at top
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count_low_reg <= `RESET_BYTE;
    end else if (wr_low) begin
      count_low_reg <= io_req_in.wdata;
    end else if (tick_in) begin
      if (at_top && !block_reg) begin
        count_low_reg <= `RESET_BYTE;
      end else begin
        count_low_reg <= count_inc[7:0];
      end
    end
  end

  // counter high byte: a narrow high write no longer steals a tick from the low byte
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      count_high_reg <= `RESET_BYTE;
    end else if (wr_low) begin
      if (wide) begin
        count_high_reg <= temp_reg;
      end
    end else if (wr_high && !wide) begin
      count_high_reg <= io_req_in.wdata;
    end else if (tick_in && wide) begin
      if (at_top && !block_reg) begin
        count_high_reg <= `RESET_BYTE;
      end else begin
        count_high_reg <= count_inc[15:8];
      end
    end
  end

  // compare registers; in capture mode compare_a (and compare_b in wide mode) also receives the captured count
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      compare_a_reg <= `RESET_BYTE;
      compare_b_reg <= `RESET_BYTE;
    end else if (capture_take) begin
      compare_a_reg <= count_low_reg;
      if (wide)
        compare_b_reg <= count_high_reg;
    end else if (wr_cmp_a) begin
      compare_a_reg <= io_req_in.wdata;
      if (wide)
        compare_b_reg <= temp_reg;
    end else if (wr_cmp_b && !wide) begin
      compare_b_reg <= io_req_in.wdata;
    end
  end

  // high halves read back the latch in wide mode so the pair is coherent
  always_comb begin
    rd_mux = `RESET_BYTE;
    case (io_req_in.addr)
      `ADDR_COUNTER_LOW: rd_mux = count_low_reg;
      `ADDR_COUNTER_HIGH: rd_mux = wide ? temp_reg : count_high_reg;
      `ADDR_COMPARE_A: rd_mux = compare_a_reg;
      `ADDR_COMPARE_B: rd_mux = wide ? temp_reg : compare_b_reg;
      `ADDR_TIMER_CTRL: rd_mux = ctrl_reg;
      `ADDR_IRQ_FLAGS: rd_mux = flags_byte;
      `ADDR_IRQ_MASK: rd_mux = mask_reg;
      default: rd_mux = `RESET_BYTE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      rdata_reg <= `RESET_BYTE;
    else if (io_req_in.rd)
      rdata_reg <= rd_mux;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in)
      count_out_reg <= `RESET_WORD;
    else
      count_out_reg <= count16;
  end

  assign rdata_out = rdata_reg;
  assign count_out = count_out_reg;
endmodule
`default_nettype wire

// file: tb/cpu_bus_model.sv
// cpu core model: one-cycle write and read strobes on the register bus
// assumes each call starts just after a rising clk_in edge
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model
  import timer0_pkg::*;
(
  input wire logic clk_in,
  output var io_req_s io_req_out
);
  initial io_req_out = '0;
  // idle bus shows inverted leftovers so a late sampler never sees a copy
  task automatic access(input logic [5:0] a, input logic w, input logic [7:0] d);
    io_req_out <= '{a, w, !w, d};
    @(posedge clk_in);
    io_req_out <= '{~a, 1'b0, 1'b0, ~d};
    @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the timer register interface
// assumes the cpu model drives the bus; the bench drives ticks, pin and acks
`timescale 1ns/1ns
`default_nettype none
`include "timer0_params.svh"
module tb_top
  import timer0_pkg::*;
;
  logic clk_in, rst_n_in, tick_in, pin, acomp, gie, rd_d;
  irq_vec_s ack, irq;
  io_req_s req;
  logic [7:0] rdata;
  logic [15:0] count, word;
  logic [7:0] exp_q[$];
  int mismatches, tests_run;
  logic [5:0] rst_addr[4] = '{6'h14, 6'h39, 6'h38, 6'h2A};
  cpu_bus_model i_cpu_bus_model (.clk_in(clk_in), .io_req_out(req));
  timer0_regs i_timer0_regs (.clk_in(clk_in), .rst_n_in(rst_n_in), .io_req_in(req),
    .rdata_out(rdata), .tick_in(tick_in), .capture_pin_in(pin), .acomp_in(acomp),
    .global_irq_en_in(gie), .vector_ack_in(ack), .irq_out(irq), .count_out(count));
  task automatic check(input string w, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_cpu_bus_model.access(a, 1'b1, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_cpu_bus_model.access(a, 1'b0, 8'h00);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      tick_in <= 1'b1;
      @(posedge clk_in);
    end
    tick_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic irq_is(input logic [3:0] e);
    @(negedge clk_in);
    check("irq", {12'h000, e}, {12'h000, irq});
    @(posedge clk_in);
  endtask
  task automatic ack_vec(input irq_vec_s v);
    ack <= v;
    @(posedge clk_in);
    ack <= 4'h0;
    @(posedge clk_in);
  endtask
  task automatic match(input logic [5:0] a, input logic [5:0] b, input int f, input int i);
    wr(b, 8'hF0);
    wr(a, 8'h05);
    wr(`ADDR_IRQ_MASK, 8'(1 << f));
    wr(`ADDR_COUNTER_LOW, 8'h05);
    ticks(1);
    rd(`ADDR_IRQ_FLAGS, 8'h00);
    wr(`ADDR_COUNTER_LOW, 8'h04);
    ticks(2);
    rd(`ADDR_IRQ_FLAGS, 8'(1 << f));
    irq_is(4'(1 << i));
    gie <= 1'b0;
    irq_is(4'h0);
    gie <= 1'b1;
  endtask
  // read data is registered on the read edge, so compare off the next falling edge
  always @(posedge clk_in) rd_d <= req.rd;
  always @(negedge clk_in) begin
    if (rd_d === 1'b1) check("rdata", {8'h00, exp_q.pop_front()}, {8'h00, rdata});
  end
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    {rst_n_in, tick_in, pin, acomp} = 4'h0;
    gie = 1'b1;
    ack = 4'h0;
    void'($urandom(42340));
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    foreach (rst_addr[k]) rd(rst_addr[k], 8'h00);
    wr(`ADDR_IRQ_MASK, 8'hFF);
    rd(`ADDR_IRQ_MASK, 8'h1B);
    wr(`ADDR_IRQ_FLAGS, 8'hFF);
    rd(`ADDR_IRQ_FLAGS, 8'h00);
    $display("test reset done");
    word = 16'($urandom);
    wr(`ADDR_TIMER_CTRL, 8'h80);
    wr(`ADDR_COUNTER_HIGH, word[15:8]);
    wr(`ADDR_COUNTER_LOW, word[7:0]);
    @(negedge clk_in);
    check("count", word, count);
    @(posedge clk_in);
    rd(`ADDR_COUNTER_LOW, word[7:0]);
    rd(`ADDR_COUNTER_HIGH, word[15:8]);
    $display("test wide access done");
    wr(`ADDR_TIMER_CTRL, 8'h00);
    match(`ADDR_COMPARE_A, `ADDR_COMPARE_B, `IRQ_COMPARE_A_BIT, 0);
    ack_vec(4'b0001);
    rd(`ADDR_IRQ_FLAGS, 8'h00);
    match(`ADDR_COMPARE_B, `ADDR_COMPARE_A, `IRQ_COMPARE_B_BIT, 1);
    wr(`ADDR_IRQ_FLAGS, 8'h08);
    rd(`ADDR_IRQ_FLAGS, 8'h00);
    $display("test narrow compare done");
    wr(`ADDR_IRQ_MASK, 8'h02);
    wr(`ADDR_COUNTER_LOW, 8'hFF);
    ticks(1);
    rd(`ADDR_IRQ_FLAGS, 8'h02);
    irq_is(4'b0100);
    ack_vec(4'b0100);
    rd(`ADDR_IRQ_FLAGS, 8'h00);
    $display("test overflow done");
    wr(`ADDR_TIMER_CTRL, 8'h80);
    wr(`ADDR_IRQ_MASK, 8'h18);
    wr(`ADDR_COMPARE_B, 8'h05);
    wr(`ADDR_COMPARE_A, 8'h05);
    wr(`ADDR_COUNTER_HIGH, 8'h05);
    wr(`ADDR_COUNTER_LOW, 8'h04);
    ticks(2);
    rd(`ADDR_IRQ_FLAGS, 8'h10);
    rd(`ADDR_COMPARE_A, 8'h05);
    rd(`ADDR_COMPARE_B, 8'h05);
    $display("test wide compare done");
    wr(`ADDR_TIMER_CTRL, 8'h50);
    wr(`ADDR_IRQ_FLAGS, 8'hFF);
    wr(`ADDR_IRQ_MASK, 8'h01);
    wr(`ADDR_COUNTER_LOW, 8'h37);
    pin <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd(`ADDR_IRQ_FLAGS, 8'h01);
    rd(`ADDR_COMPARE_A, 8'h37);
    irq_is(4'b1000);
    ack_vec(4'b1000);
    pin <= 1'b0;
    rd(`ADDR_IRQ_FLAGS, 8'h00);
    $display("test capture done");
    wr(`ADDR_TIMER_CTRL, 8'h41);
    wr(`ADDR_COMPARE_A, 8'h03);
    wr(`ADDR_COUNTER_LOW, 8'h02);
    ticks(3);
    rd(`ADDR_IRQ_FLAGS, 8'h01);
    rd(`ADDR_COUNTER_LOW, 8'h01);
    irq_is(4'b1000);
    wr(`ADDR_IRQ_FLAGS, 8'h01);
    rd(`ADDR_IRQ_FLAGS, 8'h00);
    $display("test capture top done");
    wr(`ADDR_TIMER_CTRL, 8'h60);
    pin <= 1'b1;
    repeat (8) @(posedge clk_in);
    wr(`ADDR_COUNTER_LOW, 8'h5A);
    pin <= 1'b0;
    // the filter holds the falling edge back, so the flag is still clear here
    repeat (3) @(posedge clk_in);
    rd(`ADDR_IRQ_FLAGS, 8'h00);
    repeat (4) @(posedge clk_in);
    rd(`ADDR_IRQ_FLAGS, 8'h01);
    rd(`ADDR_COMPARE_A, 8'h5A);
    wr(`ADDR_IRQ_FLAGS, 8'hFF);
    wr(`ADDR_TIMER_CTRL, 8'h58);
    acomp <= 1'b1;
    repeat (2) @(posedge clk_in);
    rd(`ADDR_IRQ_FLAGS, 8'h01);
    $display("test capture filter done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: tb/timer0_regs_chk.sv
// port assertions for the timer register interface
// assumes one clock domain; bound onto every timer0_regs instance
`timescale 1ns/1ns
`default_nettype none
`include "timer0_params.svh"
module timer0_regs_chk
  import timer0_pkg::*;
#(
  parameter int NOISE = `NOISE_SAMPLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire io_req_s io_req_in,
  input wire logic [7:0] rdata_out,
  input wire logic tick_in,
  input wire logic capture_pin_in,
  input wire logic acomp_in,
  input wire logic global_irq_en_in,
  input wire irq_vec_s vector_ack_in,
  input wire irq_vec_s irq_out,
  input wire logic [15:0] count_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic rd_fl, rd_mk, wr_fl;
  assign rd_fl = io_req_in.rd && io_req_in.addr == `ADDR_IRQ_FLAGS;
  assign rd_mk = io_req_in.rd && io_req_in.addr == `ADDR_IRQ_MASK;
  assign wr_fl = io_req_in.wr && io_req_in.addr == `ADDR_IRQ_FLAGS;
  AST_RESET_CLEAR: assert property ($rose(rst_n_in) |->
    irq_out == 4'h0 && count_out == 16'h0000 && rdata_out == 8'h00) else $error("not cleared");
  AST_IRQ_GLOBAL: assert property (!global_irq_en_in |-> irq_out == 4'h0)
    else $error("irq without global enable");
  AST_IRQ_A_CAUSE: assert property ($rose(irq_out.compare_a) |->
    $rose(global_irq_en_in) || $past(tick_in) || $past(io_req_in.wr)) else $error("irq a");
  AST_ACK_A: assert property (vector_ack_in.compare_a && !tick_in |=>
    !irq_out.compare_a) else $error("ack a kept irq");
  AST_ACK_OVF: assert property (vector_ack_in.overflow && !tick_in |=>
    !irq_out.overflow) else $error("ack overflow kept irq");
  AST_ONE_B: assert property (wr_fl && io_req_in.wdata[`IRQ_COMPARE_B_BIT] && !tick_in
    |=> !irq_out.compare_b) else $error("write one kept irq b");
  AST_COUNT_CAUSE: assert property ($changed(count_out) |->
    $past(tick_in, 2) || $past(io_req_in.wr, 2)) else $error("count moved alone");
  AST_READ_SLOT: assert property (!$stable(rdata_out) |-> $past(io_req_in.rd))
    else $error("read data moved without read");
  AST_MASK_BITS: assert property (rd_mk |=> (rdata_out & 8'hE4) == 8'h00)
    else $error("mask reserved bits");
  AST_FLAG_BITS: assert property (rd_fl |=> (rdata_out & 8'hE4) == 8'h00)
    else $error("flag reserved bits");
  COV_A: cover property (irq_out.compare_a);
  COV_OVF: cover property (irq_out.overflow);
  COV_CAPT: cover property (irq_out.capture);
endmodule
bind timer0_regs timer0_regs_chk #(.NOISE(NOISE)) i_timer0_regs_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .io_req_in(io_req_in), .rdata_out(rdata_out),
  .tick_in(tick_in), .capture_pin_in(capture_pin_in), .acomp_in(acomp_in),
  .global_irq_en_in(global_irq_en_in), .vector_ack_in(vector_ack_in),
  .irq_out(irq_out), .count_out(count_out));
`default_nettype wire
